// file: core/dwss_pkg.sv
// Shared constants and types for the write saturation and shifter datapath
package dwss_pkg;
  // Datapath widths
  localparam int ACC_W  = 40;
  localparam int WORD_W = 16;
  localparam int EXT_W  = 24;
  localparam int SUM_W  = 25;
  localparam int CNT_W  = 6;
  localparam int AMT_W  = 5;

  // Accumulator field positions
  localparam int ACC_SIGN_BIT = 39;
  localparam int HI_LSB       = 16;
  localparam int HI_MSB       = 31;
  localparam int LO_MSB       = 15;
  localparam int GUARD_LSB    = 32;

  // Saturation thresholds on the rounded 24-bit word, clamp values and the rounding half point
  localparam logic [EXT_W-1:0]  SAT_HI_IN  = 24'h007fff;
  localparam logic [EXT_W-1:0]  SAT_LO_IN  = 24'hff8000;
  localparam logic [WORD_W-1:0] SAT_POS    = 16'h7fff;
  localparam logic [WORD_W-1:0] SAT_NEG    = 16'h8000;
  localparam logic [WORD_W-1:0] ROUND_HALF = 16'h8000;

  // Shift count limit and X bus placement
  localparam logic [CNT_W-1:0] SHIFT_MAX  = 6'h10;
  localparam int               XBUS_R_LSB = 16;
  localparam int               XBUS_PAD_W = 8;

  // Shifter operand sources
  typedef enum logic [1:0] {
    SRC_ACC_A = 2'h0,
    SRC_ACC_B = 2'h1,
    SRC_XBUS  = 2'h3
  } dwss_src_type;
endpackage : dwss_pkg

// file: core/dwss_shift_if.sv
// Interface between the datapath top and the barrel shifter
`timescale 1ns/10ps
interface dwss_shift_if;
  import dwss_pkg::*;
  logic [ACC_W-1:0] operand;
  logic [AMT_W-1:0] amount;
  logic             left;
  logic             arith;
  logic [ACC_W-1:0] result;

  modport core (output operand, output amount, output left,
                output arith, input result);
  modport unit (input operand, input amount, input left,
                input arith, output result);
endinterface : dwss_shift_if

// file: core/dwss_barrel.sv
// Combinational 40-bit barrel shifter, one operation per cycle
`timescale 1ns/10ps
module dwss_barrel
  import dwss_pkg::*;
(
  dwss_shift_if.unit sh
);
  logic [ACC_W-1:0] right_val;
  logic [ACC_W-1:0] left_val;

  // Right shift keeps the sign only when arithmetic is asked for
  assign right_val = sh.arith ?
                     ACC_W'($signed(sh.operand) >>> sh.amount) :
                     (sh.operand >> sh.amount);
  assign left_val  = sh.operand << sh.amount;
  // Amount zero falls through both paths untouched
  assign sh.result = sh.left ? left_val : right_val;
endmodule : dwss_barrel

// file: core/dwss_core.sv
// Data write saturation stage and barrel shifter datapath top
`timescale 1ns/10ps
module dwss_core
  import dwss_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic [ACC_W-1:0]  acc_a_in,
  input  wire logic [ACC_W-1:0]  acc_b_in,
  input  wire logic [WORD_W-1:0] xbus_in,
  input  wire logic              data_write_saturate_enable_in,
  input  wire logic              store_valid_in,
  input  wire logic              store_acc_sel_in,
  input  wire logic              store_round_in,
  input  wire logic              store_convergent_in,
  input  wire logic              shift_valid_in,
  input  wire logic [1:0]        shift_src_in,
  input  wire logic [CNT_W-1:0]  shift_count_in,
  input  wire logic              shift_arith_in,
  output logic                   store_valid_out,
  output logic [WORD_W-1:0]      store_data_out,
  output logic                   store_sat_out,
  output logic                   shift_valid_out,
  output logic [ACC_W-1:0]       shift_result_out,
  output logic [WORD_W-1:0]      shift_word_out,
  output logic                   shift_unsup_out
);

  // ---------------- Store path: round then saturate
  logic [ACC_W-1:0]  st_acc;
  logic [WORD_W-1:0] acc_low_word;
  logic [WORD_W-1:0] acc_high_word;
  logic [EXT_W-1:0]  acc_ext;
  logic              acc_sign;
  logic              low_ge_half;
  logic              low_is_half;
  logic              round_inc;
  logic [SUM_W-1:0]  round_sum;
  logic [WORD_W-1:0] round_word;
  logic              over_pos;
  logic              over_neg;
  logic              sat_pos_hit;
  logic              sat_neg_hit;
  logic [WORD_W-1:0] next_store_data;
  logic              next_store_sat;

  // Pick the accumulator being stored; it is only read, never written
  assign st_acc        = store_acc_sel_in ? acc_b_in : acc_a_in;
  assign acc_low_word  = st_acc[LO_MSB:0];
  assign acc_high_word = st_acc[HI_MSB:HI_LSB];
  assign acc_ext       = st_acc[ACC_W-1:HI_LSB];
  assign acc_sign      = st_acc[ACC_SIGN_BIT];

  // Round increment: conventional on low half, convergent ties to even
  assign low_ge_half = (acc_low_word >= ROUND_HALF);
  assign low_is_half = (acc_low_word == ROUND_HALF);
  assign round_inc   = store_round_in &&
                       (store_convergent_in ?
                        ((low_ge_half && !low_is_half) ||
                         (low_is_half && st_acc[HI_LSB])) :
                        low_ge_half);

  // One extra bit so the round adder carry is seen as overflow
  assign round_sum  = {acc_ext[EXT_W-1], acc_ext} +
                      {{(SUM_W-1){1'b0}}, round_inc};
  assign round_word = round_sum[WORD_W-1:0];

  // Range tests against the signed 24-bit limits of a 1.15 word
  assign over_pos = $signed(round_sum) >
                    $signed({SAT_HI_IN[EXT_W-1], SAT_HI_IN});
  assign over_neg = $signed(round_sum) <
                    $signed({SAT_LO_IN[EXT_W-1], SAT_LO_IN});

  // Source sign decides which clamp applies; this also clamps the rare case
  // where rounding alone lifts a value, as the sign bit rules it
  assign sat_pos_hit = data_write_saturate_enable_in &&
                       !acc_sign && over_pos;
  assign sat_neg_hit = data_write_saturate_enable_in &&
                       acc_sign && over_neg;

  // Clamp or pass; enable clear always passes the rounded word
  assign next_store_data = sat_pos_hit ? SAT_POS :
                           sat_neg_hit ? SAT_NEG :
                           round_word;
  assign next_store_sat  = sat_pos_hit || sat_neg_hit;

  // Stored word is registered one cycle after the request
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      store_valid_out <= 1'b0;
      store_data_out  <= '0;
      store_sat_out   <= 1'b0;
    end else begin
      store_valid_out <= store_valid_in;
      if (store_valid_in) begin
        store_data_out <= next_store_data;
        store_sat_out  <= next_store_sat;
      end
    end
  end

  // ---------------- Shift path
  dwss_shift_if sh ();

  logic              cnt_neg;
  logic [CNT_W-1:0]  cnt_mag;
  logic              cnt_unsup;
  logic              xbus_sel;
  logic              x_ext;
  logic [ACC_W-1:0]  x_right_op;
  logic [ACC_W-1:0]  x_left_op;
  logic [ACC_W-1:0]  next_operand;
  logic [WORD_W-1:0] next_word;

  // Signed count: sign gives direction, magnitude gives distance
  assign cnt_neg   = shift_count_in[CNT_W-1];
  assign cnt_mag   = cnt_neg ? CNT_W'(-shift_count_in) :
                     shift_count_in;
  // Larger counts are not defined; shifter then passes the operand
  assign cnt_unsup = (cnt_mag > SHIFT_MAX);

  // X bus lands in bits 31:16 for right shifts, bits 15:0 for left
  assign xbus_sel   = (shift_src_in == SRC_XBUS);
  assign x_ext      = shift_arith_in && xbus_in[WORD_W-1];
  assign x_right_op = {{XBUS_PAD_W{x_ext}}, xbus_in,
                       {XBUS_R_LSB{1'b0}}};
  assign x_left_op  = {{(ACC_W-WORD_W){1'b0}}, xbus_in};

  // Operand select; an unused source code reads accumulator A
  assign next_operand = xbus_sel ?
                        (cnt_neg ? x_left_op : x_right_op) :
                        (shift_src_in == SRC_ACC_B) ?
                        acc_b_in : acc_a_in;

  assign sh.operand = next_operand;
  assign sh.amount  = cnt_unsup ? '0 : cnt_mag[AMT_W-1:0];
  assign sh.left    = cnt_neg;
  assign sh.arith   = shift_arith_in;

  dwss_barrel dwss_barrel_inst (
    .sh (sh.unit)
  );

  // 16-bit word result taken from the lane the X bus came in on
  assign next_word = cnt_neg ? sh.result[WORD_W-1:0] :
                     sh.result[HI_MSB:HI_LSB];

  // Result registered each cycle, so one shift per clock
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_valid_out  <= 1'b0;
      shift_result_out <= '0;
      shift_word_out   <= '0;
      shift_unsup_out  <= 1'b0;
    end else begin
      shift_valid_out <= shift_valid_in;
      if (shift_valid_in) begin
        shift_result_out <= sh.result;
        shift_word_out   <= next_word;
        shift_unsup_out  <= cnt_unsup;
      end
    end
  end

  // ---------------- Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  AST_PASS_THRU: assert property (
    store_valid_in && !data_write_saturate_enable_in |=>
      store_data_out == $past(round_word) && !store_sat_out)
    else $error("Store word changed with saturation off");

  AST_POS_CLAMP: assert property (
    store_valid_in && data_write_saturate_enable_in &&
    !acc_sign && over_pos |=> store_data_out == SAT_POS)
    else $error("Positive overflow not clamped to 7fff");

  AST_NEG_CLAMP: assert property (
    store_valid_in && data_write_saturate_enable_in &&
    acc_sign && over_neg |=> store_data_out == SAT_NEG)
    else $error("Negative overflow not clamped to 8000");

  AST_IN_RANGE: assert property (
    store_valid_in && !over_pos && !over_neg |=>
      store_data_out == $past(round_word) && !store_sat_out)
    else $error("In-range word was altered");

  AST_SIGN_SEL: assert property (
    store_valid_out && store_sat_out |->
      store_data_out[WORD_W-1] == $past(acc_sign))
    else $error("Clamp sign disagrees with bit 39");

  AST_CONV_ROUND: assert property (
    store_valid_in && store_round_in && !store_convergent_in &&
    !data_write_saturate_enable_in && low_ge_half |=>
      store_data_out == WORD_W'($past(acc_high_word) + 16'h0001))
    else $error("Conventional round did not increment");

  AST_ONE_CYCLE: assert property (
    shift_valid_in |=> shift_valid_out ##1
      (shift_valid_out == $past(shift_valid_in)))
    else $error("Shift result not one cycle later");

  AST_ZERO_CNT: assert property (
    shift_valid_in && shift_count_in == '0 &&
    shift_src_in == SRC_ACC_A |=> shift_result_out == $past(acc_a_in))
    else $error("Zero count modified operand");

  AST_RIGHT_LOG: assert property (
    shift_valid_in && !cnt_neg && !cnt_unsup && !shift_arith_in &&
    shift_src_in == SRC_ACC_B |=>
      shift_result_out == ($past(acc_b_in) >> $past(cnt_mag)))
    else $error("Positive count did not shift right");

  AST_LEFT_SHIFT: assert property (
    shift_valid_in && cnt_neg && !cnt_unsup &&
    shift_src_in == SRC_ACC_A |=>
      shift_result_out == ($past(acc_a_in) << $past(cnt_mag)))
    else $error("Negative count did not shift left");

  AST_XBUS_LANE: assert property (
    shift_valid_in && xbus_sel && !cnt_neg && !cnt_unsup &&
    !shift_arith_in |=>
      shift_word_out == WORD_W'($past(xbus_in) >> $past(cnt_mag)))
    else $error("X bus right shift in wrong lane");

  AST_ACC_SRC: assert property (
    shift_valid_in && shift_count_in == '0 &&
    shift_src_in == SRC_ACC_B |=> shift_result_out == $past(acc_b_in))
    else $error("Accumulator B not selected");

  AST_RIGHT_ARITH: assert property (
    shift_valid_in && !cnt_neg && !cnt_unsup && shift_arith_in &&
    shift_src_in == SRC_ACC_A |=>
      shift_result_out ==
      ACC_W'($signed($past(acc_a_in)) >>> $past(cnt_mag)))
    else $error("Arithmetic right shift lost the sign");

  AST_XBUS_LEFT: assert property (
    shift_valid_in && xbus_sel && cnt_neg && !cnt_unsup |=>
      shift_result_out == ({{(ACC_W-WORD_W){1'b0}}, $past(xbus_in)} <<
                           $past(cnt_mag)))
    else $error("X bus left shift in wrong lane");

  AST_WORD_LEFT: assert property (
    shift_valid_in && cnt_neg |=>
      shift_word_out == shift_result_out[WORD_W-1:0])
    else $error("Left shift word not from low lane");

  AST_WORD_RIGHT: assert property (
    shift_valid_in && !cnt_neg |=>
      shift_word_out == shift_result_out[HI_MSB:HI_LSB])
    else $error("Right shift word not from middle lane");

  AST_UNSUP_PASS: assert property (
    shift_valid_in && cnt_unsup && shift_src_in == SRC_ACC_B |=>
      shift_unsup_out && shift_result_out == $past(acc_b_in))
    else $error("Unsupported count did not pass operand");

  AST_TRUNCATE: assert property (
    store_valid_in && !store_round_in &&
    !data_write_saturate_enable_in |=>
      store_data_out == $past(acc_high_word))
    else $error("Truncated store is not the high word");

  AST_CONV_TIE: assert property (
    store_valid_in && store_round_in && store_convergent_in &&
    !data_write_saturate_enable_in && low_is_half && !st_acc[HI_LSB] |=>
      store_data_out == $past(acc_high_word))
    else $error("Convergent tie with even high word rounded up");

  AST_STORE_PULSE: assert property (
    store_valid_in |=> store_valid_out)
    else $error("Store answer missing one cycle later");

  AST_SAT_NEEDS_EN: assert property (
    store_valid_out && store_sat_out |->
      $past(data_write_saturate_enable_in))
    else $error("Clamp flagged with saturation off");

  COV_POS_SAT: cover property (
    store_valid_in && sat_pos_hit ##1 store_sat_out);
  COV_NEG_SAT: cover property (
    store_valid_in && sat_neg_hit ##1 store_sat_out);
  COV_XBUS_LEFT: cover property (
    shift_valid_in && xbus_sel && cnt_neg && !cnt_unsup);
  COV_BACK2BACK: cover property (shift_valid_in [*3]);
  COV_CONV_TIE: cover property (
    store_valid_in && store_convergent_in && low_is_half);

endmodule : dwss_core

// file: dv/dwss_cpu_model.sv
// Model of the accumulators and X data bus that feed the datapath
`timescale 1ns/10ps
module dwss_cpu_model
  import dwss_pkg::*;
(
  input  wire logic              clk_sys_in,
  output logic      [ACC_W-1:0]  acc_a_out,
  output logic      [ACC_W-1:0]  acc_b_out,
  output logic      [WORD_W-1:0] xbus_out
);
  // Cleared at start so the core never sees unknown operands
  initial begin
    acc_a_out = 40'h0;
    acc_b_out = 40'h0;
    xbus_out  = 16'h0;
  end

  // New contents land just after an edge, as the CPU writes them
  task automatic load(input logic [ACC_W-1:0] a, input logic [ACC_W-1:0] b,
                      input logic [WORD_W-1:0] x);
    @(posedge clk_sys_in);
    acc_a_out <= a;
    acc_b_out <= b;
    xbus_out  <= x;
  endtask : load
endmodule : dwss_cpu_model

// file: dv/dsp_write_saturation_shifter_test.sv
// Self-checking bench for the write saturation and shifter datapath
`timescale 1ns/10ps
module dsp_write_saturation_shifter_test;
  import dwss_pkg::*;
  logic clk_sys_in, rst_n_in, sat_en, st_valid, st_sel, st_rnd, st_conv;
  logic sh_valid, sh_arith, so_valid, so_sat, ho_valid, ho_unsup;
  logic [1:0]  sh_src;
  logic [5:0]  sh_cnt;
  logic [15:0] so_data, ho_word, xbus;
  logic [39:0] acc_a, acc_b, ho_result;
  int          errors, total_checks, cycles;

  dwss_cpu_model dwss_cpu_model_inst (.clk_sys_in(clk_sys_in),
    .acc_a_out(acc_a), .acc_b_out(acc_b), .xbus_out(xbus));
  dwss_core dwss_core_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .acc_a_in(acc_a), .acc_b_in(acc_b), .xbus_in(xbus),
    .data_write_saturate_enable_in(sat_en), .store_valid_in(st_valid),
    .store_acc_sel_in(st_sel), .store_round_in(st_rnd),
    .store_convergent_in(st_conv), .shift_valid_in(sh_valid),
    .shift_src_in(sh_src), .shift_count_in(sh_cnt),
    .shift_arith_in(sh_arith), .store_valid_out(so_valid),
    .store_data_out(so_data), .store_sat_out(so_sat),
    .shift_valid_out(ho_valid), .shift_result_out(ho_result),
    .shift_word_out(ho_word), .shift_unsup_out(ho_unsup));

  // Free-running 4 ns clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard, far above the fewer than 100 cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One store request, judged in the cycle its answer stands
  task automatic store(input logic en, sel, rnd, conv,
                       input logic [15:0] d, input logic s);
    @(posedge clk_sys_in);
    sat_en   <= en;
    st_sel   <= sel;
    st_rnd   <= rnd;
    st_conv  <= conv;
    st_valid <= 1'b1;
    @(posedge clk_sys_in);
    st_valid <= 1'b0;
    #1;
    chk(so_valid, 1'b1);
    chk(so_data, d);
    chk(so_sat, s);
  endtask : store

  // One shift request; counts kept within sixteen unless refusal is meant
  task automatic shift(input logic [1:0] src, input logic [5:0] cnt,
                       input logic ar, input logic [39:0] r,
                       input logic [15:0] w, input logic u);
    @(posedge clk_sys_in);
    sh_src   <= src;
    sh_cnt   <= cnt;
    sh_arith <= ar;
    sh_valid <= 1'b1;
    @(posedge clk_sys_in);
    sh_valid <= 1'b0;
    #1;
    chk(ho_valid, 1'b1);
    chk(ho_result, r);
    chk(ho_word, w);
    chk(ho_unsup, u);
  endtask : shift

  task automatic t_clamp;
    dwss_cpu_model_inst.load(40'h00_8000_0000, 40'hff_7fff_0000, 16'h0);
    store(1, 0, 0, 0, 16'h7fff, 1);
    store(1, 1, 0, 0, 16'h8000, 1);
    dwss_cpu_model_inst.load(40'h00_7fff_8000, 40'hff_8000_0000, 16'h0);
    store(1, 0, 1, 0, 16'h7fff, 1);
    store(1, 0, 0, 0, 16'h7fff, 0);
    store(1, 1, 0, 0, 16'h8000, 0);
    dwss_cpu_model_inst.load(40'h80_1234_0000, 40'h7f_ffff_0000, 16'h0);
    store(1, 0, 0, 0, 16'h8000, 1);
    store(1, 1, 0, 0, 16'h7fff, 1);
    $display("test clamp done");
  endtask : t_clamp

  task automatic t_pass;
    dwss_cpu_model_inst.load(40'h00_8000_0000, 40'hff_7fff_0000, 16'h0);
    store(0, 0, 0, 0, 16'h8000, 0);
    store(0, 1, 0, 0, 16'h7fff, 0);
    dwss_cpu_model_inst.load(40'h00_7fff_8000, 40'h0, 16'h0);
    store(0, 0, 1, 0, 16'h8000, 0);
    $display("test pass-through done");
  endtask : t_pass

  task automatic t_round;
    dwss_cpu_model_inst.load(40'h00_1234_8000, 40'h00_1235_8000, 16'h0);
    store(1, 0, 1, 0, 16'h1235, 0);
    store(1, 0, 1, 1, 16'h1234, 0);
    store(1, 1, 1, 1, 16'h1236, 0);
    store(1, 1, 0, 0, 16'h1235, 0);
    $display("test round done");
  endtask : t_round

  task automatic t_shift_acc;
    dwss_cpu_model_inst.load(40'h80_0000_0010, 40'h12_3456_789a, 16'h0);
    shift(SRC_ACC_A, 6'h04, 1, 40'hf8_0000_0001, 16'h0000, 0);
    shift(SRC_ACC_A, 6'h04, 0, 40'h08_0000_0001, 16'h0000, 0);
    shift(2'h2, 6'h04, 0, 40'h08_0000_0001, 16'h0000, 0);
    shift(SRC_ACC_B, 6'h3c, 0, 40'h23_4567_89a0, 16'h89a0, 0);
    shift(SRC_ACC_B, 6'h30, 0, 40'h56_789a_0000, 16'h0000, 0);
    shift(SRC_ACC_B, 6'h10, 0, 40'h00_0012_3456, 16'h0012, 0);
    shift(SRC_ACC_B, 6'h00, 1, 40'h12_3456_789a, 16'h3456, 0);
    shift(SRC_ACC_B, 6'h11, 0, 40'h12_3456_789a, 16'h3456, 1);
    $display("test accumulator shift done");
  endtask : t_shift_acc

  task automatic t_shift_x;
    dwss_cpu_model_inst.load(40'h0, 40'h0, 16'h8421);
    shift(SRC_XBUS, 6'h04, 1, 40'hff_f842_1000, 16'hf842, 0);
    shift(SRC_XBUS, 6'h04, 0, 40'h00_0842_1000, 16'h0842, 0);
    shift(SRC_XBUS, 6'h3d, 0, 40'h00_0004_2108, 16'h2108, 0);
    $display("test X bus shift done");
  endtask : t_shift_x

  // Three shifts on consecutive edges, each answer judged while it stands
  task automatic t_back2back;
    dwss_cpu_model_inst.load(40'h0, 40'h12_3456_789a, 16'h0);
    @(posedge clk_sys_in);
    sh_src   <= SRC_ACC_B;
    sh_arith <= 1'b0;
    sh_cnt   <= 6'h04;
    sh_valid <= 1'b1;
    @(posedge clk_sys_in);
    sh_cnt <= 6'h3c;
    #1;
    chk(ho_result, 40'h01_2345_6789);
    @(posedge clk_sys_in);
    sh_cnt <= 6'h00;
    #1;
    chk(ho_result, 40'h23_4567_89a0);
    @(posedge clk_sys_in);
    sh_valid <= 1'b0;
    #1;
    chk(ho_valid, 1'b1);
    chk(ho_result, 40'h12_3456_789a);
    $display("test back-to-back shift done");
  endtask : t_back2back

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Main sequence: reset held for 12 cycles, then every scenario
  initial begin
    {rst_n_in, sat_en, st_valid, st_sel, st_rnd, st_conv} = 6'h0;
    {sh_valid, sh_src, sh_cnt, sh_arith} = 10'h0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    chk(so_valid, 1'b0);
    chk(ho_result, 40'h0);
    t_clamp();
    t_pass();
    t_round();
    t_shift_acc();
    t_shift_x();
    t_back2back();
    results();
  end
endmodule : dsp_write_saturation_shifter_test
